// [rtl/i2stdm_pkg.sv]
/*
 Constants for the serial audio port: register map, field positions,
 reset values, framing formats and link timing.
 Assumes a single system clock of SYS_CLK_HZ.
*/
package i2stdm_pkg;
    // System clock and link ceiling
    localparam int unsigned SYS_CLK_HZ = 20_000_000;
    localparam int unsigned BCLK_MAX_HZ = 24_576_000;
    // Least half period in system cycles, rounded up, at least one
    localparam int unsigned BCLK_MIN_HALF =
        (SYS_CLK_HZ + 2 * BCLK_MAX_HZ - 1) / (2 * BCLK_MAX_HZ);
    localparam int unsigned SLOT_BITS = 32;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLKDIV = 8'h04;
    localparam logic [7:0] OFS_FRAME = 8'h08;
    localparam logic [7:0] OFS_TXMASK = 8'h0c;
    localparam logic [7:0] OFS_RXMASK = 8'h10;
    localparam logic [7:0] OFS_TXDATA = 8'h14;
    localparam logic [7:0] OFS_RXDATA = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    // Control field positions
    localparam int CTL_EN = 0;
    localparam int CTL_INIT = 1;
    localparam int CTL_TXEN = 2;
    localparam int CTL_RXEN = 3;
    localparam int CTL_FMT = 4;
    localparam int CTL_FSLONG = 7;
    localparam int CTL_FSRISE = 8;
    localparam int CTL_HIZ = 9;
    // Frame field positions
    localparam int FRM_NSLOT = 0;
    localparam int FRM_LEN = 8;
    // Status field positions
    localparam int STA_TXFULL = 0;
    localparam int STA_RXVAL = 1;
    localparam int STA_UNDER = 2;
    localparam int STA_OVER = 3;
    // Reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_CLKDIV = 32'h0000_0003;
    localparam logic [31:0] RST_FRAME = 32'h0000_1f01;
    localparam logic [31:0] RST_MASK = 32'h0000_0003;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Framing formats
    typedef enum logic [2:0] {
        FMT_I2S, FMT_LEFT_JUST, FMT_RIGHT_JUST, FMT_DSP, FMT_PCM, FMT_TDM
    } i2stdm_fmt_e;
endpackage : i2stdm_pkg

// [rtl/i2stdm_port.sv]
/*
 Serial audio port with AXI4-Lite register slave. One word holding
 register per direction gives the stream flow control.
 Assumes i_bclk, i_fsync and i_sdin are asynchronous pins.
*/
// How it works
// - full duplex, transmit only or receive only
// - bit clock kept below 24.576 MHz
// - I2S, right, left justified, DSP framing
// - PCM frame sync one or two bits
// - separate transmit and receive slot masks
// - programmable slot count, only selected slots
// - data output released outside owned slots
// - stalls writes, flags underrun and overrun
// - frame sync sampled on falling edge option
`timescale 1ns/1ns
module i2stdm_port
    import i2stdm_pkg::*;
(
    input wire logic i_sys_clk, // System clock
    input wire logic i_nrst, // Async reset, low
    input wire logic [7:0] i_awaddr, // Write address
    input wire logic i_awvalid, // Write address valid
    output logic o_awready, // Write address ready
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_wstrb, // Byte enables
    input wire logic i_wvalid, // Write data valid
    output logic o_wready, // Write data ready
    output logic [1:0] o_bresp, // Write response
    output logic o_bvalid, // Write response valid
    input wire logic i_bready, // Write response ready
    input wire logic [7:0] i_araddr, // Read address
    input wire logic i_arvalid, // Read address valid
    output logic o_arready, // Read address ready
    output logic [31:0] o_rdata, // Read data
    output logic [1:0] o_rresp, // Read response
    output logic o_rvalid, // Read data valid
    input wire logic i_rready, // Read data ready
    input wire logic i_bclk, // Bit clock pin in
    output logic o_bclk, // Bit clock pin out
    output logic o_bclk_oe, // Bit clock drive enable
    input wire logic i_fsync, // Frame sync pin in
    output logic o_fsync, // Frame sync pin out
    output logic o_fsync_oe, // Frame sync drive enable
    input wire logic i_sdin, // Serial data in
    output logic o_sdout, // Serial data out
    output logic o_sdout_oe // Serial data drive enable
);
    import i2stdm_pkg::*;
    logic [31:0] ctrl_r, div_r, frame_r, txm_r, rxm_r; // Config
    logic [2:0] bs_r, fs_r, ds_r; // Pin synchronisers
    logic bf_r, ff_r, df_r; // Filtered pin levels
    logic [7:0] hc_r; // Half period counter
    logic bo_r, fo_r, so_r, own_r; // Link outputs
    logic fsf_r, fsp_r; // Falling-edge frame sync, last frame sync
    logic [9:0] cnt_r; // Bit position in frame
    logic [31:0] txh_r, txs_r, rxh_r, rxs_r; // Holding and shift words
    logic txv_r, rxv_r, und_r, ovr_r, bv_r, rv_r; // Flags
    logic [1:0] br_r, rr_r; // Responses
    logic [31:0] rd_r; // Read data
    logic [3:0] fsh_r; // Bits with frame sync high
    // Mode decode
    wire en = ctrl_r[CTL_EN];
    wire init = ctrl_r[CTL_INIT];
    wire [2:0] fmt = ctrl_r[CTL_FMT +: 3];
    wire stereo = fmt <= 3'(FMT_RIGHT_JUST);
    wire pulse = !stereo;
    wire dly = fmt == 3'(FMT_I2S) || fmt == 3'(FMT_DSP);
    wire [4:0] nsm1 = stereo ? 5'h01 : {1'b0, frame_r[FRM_NSLOT +: 4]};
    wire [4:0] lenm1 = frame_r[FRM_LEN +: 5];
    wire [9:0] flen = {nsm1 + 5'h01, 5'h00};
    wire [9:0] half = {1'b0, flen[9:1]};
    // Bit clock events, own divider or followed pin
    wire gen_tog = en && init && hc_r == 8'h00;
    wire t_chg = ds_eq(bs_r) && bs_r[1] != bf_r;
    wire rise = init ? gen_tog && !bo_r : en && t_chg && bs_r[1];
    wire fall = init ? gen_tog && bo_r : en && t_chg && !bs_r[1];
    // Frame position, resync in target mode
    wire fs_now = ctrl_r[CTL_FSRISE] ? fsf_r : ff_r;
    wire start = !init && (fmt == 3'(FMT_I2S) ?
        (fsp_r && !fs_now) : (!fsp_r && fs_now));
    wire [9:0] nxt = cnt_r + 10'h001 >= flen ? 10'h000 : cnt_r + 10'h001;
    wire [9:0] c_now = start ? 10'h000 : nxt;
    wire [9:0] k_rx = c_now < 10'(dly) ? c_now + flen - 10'h001
                                        : c_now - 10'(dly);
    wire [9:0] k_tx = nxt < 10'(dly) ? nxt + flen - 10'h001
                                      : nxt - 10'(dly);
    // Position of a bit in its sample, right justified offset
    wire [4:0] off = fmt == 3'(FMT_RIGHT_JUST) ? 5'h1f - lenm1 : 5'h00;
    wire [4:0] rbp = k_rx[4:0] - off;
    wire [4:0] tbp = k_tx[4:0] - off;
    wire rx_in = k_rx[4:0] >= off && rbp <= lenm1;
    wire tx_in = k_tx[4:0] >= off && tbp <= lenm1;
    wire [4:0] rx_idx = lenm1 - rbp;
    wire [4:0] tx_idx = lenm1 - tbp;
    wire rx_own = rxm_r[k_rx[8:5]] && {1'b0, k_rx[8:5]} <= nsm1;
    wire tx_own = txm_r[k_tx[8:5]] && {1'b0, k_tx[8:5]} <= nsm1;
    // Initiator's first rise has no bit behind it; a push there
    // would hand software a stale shift word
    wire framed = !init || cnt_r != 10'h3ff;
    wire do_rx = en && ctrl_r[CTL_RXEN] && rise && rx_own && framed;
    wire do_tx = en && ctrl_r[CTL_TXEN] && fall;
    wire tx_load = do_tx && tx_own && k_tx[4:0] == 5'h00;
    wire [31:0] tx_word = tx_load ? (txv_r ? txh_r : 32'h0) : txs_r;
    wire [31:0] rx_word = rx_in ? (rxs_r | (32'(df_r) << rx_idx)) : rxs_r;
    wire rx_push = do_rx && k_rx[4:0] == 5'h1f;
    // Initiator frame sync shape for next bit
    wire [9:0] fsw = ctrl_r[CTL_FSLONG] ? 10'h002 : 10'h001;
    wire fs_gen = pulse ? nxt < fsw :
        (fmt == 3'(FMT_I2S) ? nxt >= half : nxt < half);
    // Register bus decode
    wire wr_go = i_awvalid && i_wvalid && !bv_r &&
        !(i_awaddr == OFS_TXDATA && txv_r);
    wire rd_go = i_arvalid && !rv_r;
    wire [31:0] wm = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}},
                      {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
    wire w_ok = i_awaddr[7:5] == 3'h0 && i_awaddr[1:0] == 2'h0 &&
        i_awaddr != OFS_RXDATA && i_awaddr != OFS_STATUS ||
        i_awaddr == OFS_STATUS;
    wire r_ok = i_araddr[7:5] == 3'h0 && i_araddr[1:0] == 2'h0;
    wire pop = rd_go && i_araddr == OFS_RXDATA;
    wire wr_sta = wr_go && i_awaddr == OFS_STATUS;
    wire [31:0] sta = {28'h0, ovr_r, und_r, rxv_r, txv_r};
    wire [31:0] rmux = i_araddr == OFS_CTRL ? ctrl_r :
        i_araddr == OFS_CLKDIV ? div_r : i_araddr == OFS_FRAME ? frame_r :
        i_araddr == OFS_TXMASK ? txm_r : i_araddr == OFS_RXMASK ? rxm_r :
        i_araddr == OFS_RXDATA ? rxh_r : i_araddr == OFS_STATUS ? sta :
        32'h0;
    wire [7:0] hmax = div_r[7:0] < 8'(BCLK_MIN_HALF) ?
        8'(BCLK_MIN_HALF) : div_r[7:0];
    assign o_awready = wr_go;
    assign o_wready = wr_go;
    assign o_bvalid = bv_r;
    assign o_bresp = br_r;
    assign o_arready = rd_go;
    assign o_rvalid = rv_r;
    assign o_rresp = rr_r;
    assign o_rdata = rd_r;
    assign o_bclk = bo_r;
    assign o_fsync = fo_r;
    assign o_sdout = so_r;
    assign o_bclk_oe = en && init;
    assign o_fsync_oe = en && init;
    assign o_sdout_oe = en && ctrl_r[CTL_TXEN] &&
        (!ctrl_r[CTL_HIZ] || own_r);
    // Second and third stage agree
    function automatic logic ds_eq(input logic [2:0] s);
        ds_eq = s[1] == s[2];
    endfunction : ds_eq
    // Pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bs_r <= 3'h0;
            fs_r <= 3'h0;
            ds_r <= 3'h0;
            bf_r <= 1'b0;
            ff_r <= 1'b0;
            df_r <= 1'b0;
        end else begin
            bs_r <= {bs_r[1:0], i_bclk};
            fs_r <= {fs_r[1:0], i_fsync};
            ds_r <= {ds_r[1:0], i_sdin};
            if (ds_eq(bs_r)) bf_r <= bs_r[1];
            if (ds_eq(fs_r)) ff_r <= fs_r[1];
            if (ds_eq(ds_r)) df_r <= ds_r[1];
        end
    end
    // Link engine: divider, frame position, shifting
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hc_r <= 8'h00;
            bo_r <= 1'b0;
            fo_r <= 1'b0;
            so_r <= 1'b0;
            own_r <= 1'b0;
            fsf_r <= 1'b0;
            fsp_r <= 1'b0;
            cnt_r <= 10'h3ff;
            txs_r <= 32'h0;
            rxs_r <= 32'h0;
            fsh_r <= 4'h0;
        end else if (!en) begin
            // Idle: restart frame at position zero
            hc_r <= 8'h00;
            bo_r <= 1'b0;
            fo_r <= 1'b0;
            own_r <= 1'b0;
            cnt_r <= 10'h3ff;
            fsh_r <= 4'h0;
        end else begin
            hc_r <= (!init || hc_r == 8'h00) ? hmax : hc_r - 8'h01;
            if (gen_tog) bo_r <= !bo_r;
            if (fall) fsf_r <= ff_r;
            if (rise) begin
                fsp_r <= fs_now;
                cnt_r <= init ? nxt : c_now;
                rxs_r <= k_rx[4:0] == 5'h00 ? 32'h0 : rx_word;
                if (k_rx[4:0] == 5'h00 && rx_in)
                    rxs_r <= 32'(df_r) << rx_idx;
                fsh_r <= o_fsync ? fsh_r + 4'h1 : 4'h0;
            end
            if (fall && init) fo_r <= fs_gen;
            if (do_tx) begin
                own_r <= tx_own;
                txs_r <= tx_word;
                so_r <= tx_own && tx_in && tx_word[tx_idx];
            end
        end
    end
    // Config registers with byte enables
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_r <= RST_CTRL;
            div_r <= RST_CLKDIV;
            frame_r <= RST_FRAME;
            txm_r <= RST_MASK;
            rxm_r <= RST_MASK;
        end else if (wr_go) begin
            case (i_awaddr)
                OFS_CTRL: ctrl_r <= (ctrl_r & ~wm) | (i_wdata & wm);
                OFS_CLKDIV: div_r <= (div_r & ~wm) | (i_wdata & wm);
                OFS_FRAME: frame_r <= (frame_r & ~wm) | (i_wdata & wm);
                OFS_TXMASK: txm_r <= (txm_r & ~wm) | (i_wdata & wm);
                OFS_RXMASK: rxm_r <= (rxm_r & ~wm) | (i_wdata & wm);
                default: ; // Data, status and holes store nothing
            endcase
        end
    end
    // Holding words and sticky flags; a set beats a clear
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            txh_r <= 32'h0;
            txv_r <= 1'b0;
            rxh_r <= 32'h0;
            rxv_r <= 1'b0;
            und_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            if (wr_go && i_awaddr == OFS_TXDATA) begin
                txh_r <= i_wdata;
                txv_r <= 1'b1;
            end else if (tx_load) txv_r <= 1'b0;
            if (rx_push && (!rxv_r || pop)) begin
                rxh_r <= rx_word;
                rxv_r <= 1'b1;
            end else if (pop) rxv_r <= 1'b0;
            und_r <= (tx_load && !txv_r) ||
                (und_r && !(wr_sta && i_wdata[STA_UNDER]));
            ovr_r <= (rx_push && rxv_r && !pop) ||
                (ovr_r && !(wr_sta && i_wdata[STA_OVER]));
        end
    end
    // AXI4-Lite responses
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bv_r <= 1'b0;
            br_r <= RESP_OKAY;
            rv_r <= 1'b0;
            rr_r <= RESP_OKAY;
            rd_r <= 32'h0;
        end else begin
            if (wr_go) begin
                bv_r <= 1'b1;
                br_r <= w_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (i_bready) bv_r <= 1'b0;
            if (rd_go) begin
                rv_r <= 1'b1;
                rr_r <= r_ok ? RESP_OKAY : RESP_SLVERR;
                rd_r <= r_ok ? rmux : 32'h0;
            end else if (i_rready) rv_r <= 1'b0;
        end
    end
    // Checks
    property p_hiz;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (ctrl_r[CTL_HIZ] && !own_r) |-> !o_sdout_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("drive outside slot");
    property p_tgt;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !init |-> !o_bclk_oe && !o_fsync_oe;
    endproperty
    a_tgt: assert property (p_tgt) else $error("target drives clock");
    property p_fsw;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (en && init && pulse) |-> fsh_r <= 4'(fsw);
    endproperty
    a_fsw: assert property (p_fsw) else $error("sync pulse too long");
    property p_stall;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_awaddr == OFS_TXDATA && txv_r) |-> !o_awready;
    endproperty
    a_stall: assert property (p_stall) else $error("tx overwrite");
    property p_ovr;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (rx_push && rxv_r && !pop) |=> ovr_r && rxv_r;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");
    sequence s_tog;
        $changed(o_bclk) ##1 $stable(o_bclk);
    endsequence
    property p_half;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (init && $changed(o_bclk)) |-> s_tog;
    endproperty
    a_half: assert property (p_half) else $error("bit clock too fast");
    property p_txen;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !ctrl_r[CTL_TXEN] |-> !o_sdout_oe;
    endproperty
    a_txen: assert property (p_txen) else $error("drive while off");
    property p_rxslot;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        rx_push |-> rxm_r[k_rx[8:5]] && ctrl_r[CTL_RXEN];
    endproperty
    a_rxslot: assert property (p_rxslot) else $error("foreign slot");
endmodule : i2stdm_port

// [verification/i2stdm_codec.sv]
/*
 Behavioural codec on the far side of the serial audio port.
 Assumes the port is target in TDM, two 32-bit slots, slot 0 owned.
*/
`timescale 1ns/1ns
module i2stdm_codec (
    input wire logic i_run, // Frames run while high
    input wire logic [31:0] i_word, // Word sent in slot 0
    input wire logic i_sd, // Port data out
    input wire logic i_sd_oe, // Port data enable
    output logic o_bclk, // Bit clock to port
    output logic o_fsync, // Frame pulse to port
    output logic o_sd, // Data to port
    output logic [31:0] o_cap, // Slot 0 seen last frame
    output logic [7:0] o_nfrm // Frames completed
);
    logic [31:0] cap_r; // Shift in progress
    initial {o_bclk, o_fsync, o_sd, o_cap, o_nfrm, cap_r} = '0;
    // Clock stands still between runs; the 13 ns offset keeps
    // its edges clear of the system clock edges
    always begin
        wait (i_run);
        #13;
        while (i_run) begin
            for (int b = 0; b < 64; b++) begin
                o_fsync = (b == 0);
                // Outside slot 0 the line toggles, never holds
                o_sd = (b < 32) ? i_word[31 - b] : ~o_sd;
                #200 o_bclk = 1'b1;
                if (b < 32) cap_r = {cap_r[30:0], i_sd_oe ? i_sd : ~cap_r[0]};
                #200 o_bclk = 1'b0;
            end
            o_cap = cap_r;
            o_nfrm = o_nfrm + 8'h01;
        end
    end
endmodule : i2stdm_codec

// [verification/testbench.sv]
/*
 Self-checking bench for the serial audio port: register reset,
 target TDM against the codec model, initiator I2S in loopback.
 Assumes the codec model and the port package.
*/
`timescale 1ns/1ns
module testbench;
    import i2stdm_pkg::*;
    logic clk = 1'b0; // System clock
    logic nrst = 1'b0; // Reset, low
    logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Bus addresses
    logic [31:0] wdata = 32'h0, rdata, cap; // Bus data, capture
    logic [3:0] wstrb = 4'h0; // Byte enables
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
    logic [1:0] bresp, rresp; // Responses
    logic bclk_o, bclk_oe, fs_o, fs_oe, sd_o, sd_oe; // Port pins out
    logic c_bclk, c_fs, c_sd, lb_sd = 1'b0, run = 1'b0; // Link side
    logic [7:0] nfrm; // Codec frame count
    int failures = 0, total_checks = 0, cyc = 0, oe_hi = 0, oe_lo = 0;
    localparam logic [31:0] WA = 32'hc3a5_0f96, WB = 32'h5a3c_81e7;
    localparam logic [31:0] WR = 32'h9e17_4b2d; // Codec word
    always #25 clk = ~clk;
    i2stdm_port i2stdm_port_inst (.i_sys_clk(clk), .i_nrst(nrst),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready), .i_bclk(c_bclk),
        .o_bclk(bclk_o), .o_bclk_oe(bclk_oe), .i_fsync(c_fs),
        .o_fsync(fs_o), .o_fsync_oe(fs_oe), .i_sdin(run ? c_sd : lb_sd),
        .o_sdout(sd_o), .o_sdout_oe(sd_oe));
    i2stdm_codec i2stdm_codec_inst (.i_run(run), .i_word(WR),
        .i_sd(sd_o), .i_sd_oe(sd_oe), .o_bclk(c_bclk), .o_fsync(c_fs),
        .o_sd(c_sd), .o_cap(cap), .o_nfrm(nfrm));
    // Loopback line; released output shows the inverse, not a hold
    always @(posedge clk) begin
        lb_sd <= (sd_oe === 1'b1) ? sd_o : ~lb_sd;
        cyc <= cyc + 1;
        if (run && sd_oe === 1'b1) oe_hi <= oe_hi + 1;
        else if (run) oe_lo <= oe_lo + 1;
        if (cyc == 40000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic t_regs;
        logic [7:0] a [5] = '{OFS_CTRL, OFS_CLKDIV, OFS_FRAME, OFS_TXMASK,
            OFS_RXMASK};
        logic [31:0] e [5] = '{RST_CTRL, RST_CLKDIV, RST_FRAME, RST_MASK,
            RST_MASK};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 5; i++) begin
            rd(a[i], d, r);
            chk(d, e[i]);
        end
        rd(8'h20, d, r); // Unmapped place
        chk({d[31:2], r}, {30'h0, RESP_SLVERR});
    endtask : t_regs
    // Target TDM, hiz on, slot 0 both ways, one word queued ahead
    task automatic t_target;
        logic [31:0] got [8];
        logic [31:0] d;
        logic [1:0] r;
        int k;
        wr(OFS_CTRL, 32'h0000_025c);
        wr(OFS_TXMASK, 32'h1);
        wr(OFS_RXMASK, 32'h1);
        wr(OFS_TXDATA, WA);
        wr(OFS_CTRL, 32'h0000_025d);
        run <= 1'b1;
        wr(OFS_TXDATA, WB); // Stalls until the first word leaves
        for (int i = 0; i < 6; i++) begin
            @(nfrm);
            got[i] = cap;
        end
        run <= 1'b0;
        chk({30'h0, bclk_oe, fs_oe}, 32'h0);
        k = 0;
        while (k < 3 && got[k] !== WA) k++;
        chk(got[k], WA);
        chk(got[k + 1], WB);
        chk(got[k + 2], 32'h0);
        chk({31'h0, oe_hi > 0 && oe_lo > 0}, 32'h1);
        rd(OFS_STATUS, d, r);
        chk(d & 32'hf, 32'he);
        rd(OFS_RXDATA, d, r);
        chk(d, WR);
        wr(OFS_STATUS, 32'hc);
        rd(OFS_STATUS, d, r);
        chk(d & 32'hf, 32'h0);
    endtask : t_target
    // Initiator I2S, data looped back, half period of ten cycles
    task automatic t_init;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CLKDIV, 32'h9);
        wr(OFS_CTRL, 32'h0000_000e);
        wr(OFS_TXDATA, WA);
        wr(OFS_CTRL, 32'h0000_000f);
        chk({30'h0, bclk_oe, fs_oe}, 32'h3);
        n = 0;
        do @(posedge clk); while (bclk_o !== 1'b1);
        while (bclk_o === 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(n, 32'd10);
        do rd(OFS_STATUS, d, r); while (d[STA_RXVAL] !== 1'b1);
        rd(OFS_RXDATA, d, r);
        chk(d, WA);
        wr(OFS_CTRL, 32'h0);
        // Initiator PCM, long sync: second pulse spans two bits
        wr(OFS_CTRL, 32'h0000_00c3);
        repeat (2) begin
            do @(posedge clk); while (fs_o !== 1'b1);
            n = 0;
            while (fs_o === 1'b1) begin
                @(posedge clk);
                n++;
            end
        end
        chk(n, 32'd40);
        wr(OFS_CTRL, 32'h0);
    endtask : t_init
    task automatic report_and_stop;
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_target();
        t_init();
        report_and_stop();
    end
endmodule : testbench
